// ===== dbg_csh_pkg.sv
// constants for the upper debug control and status byte
// Function
// - bit 7 debug enable allows active debug mode and intrusive commands
// - debug enable resets to 1 in special single-chip mode
// - bit 6 set on active debug entry, cleared on exit sequence
// - active debug status resets to 1 in special single-chip mode
// - bit 5 picks serial clock only or all clocks in stop mode
// - with debug disabled, no stop influence and no serial communication in stop mode
// - with handshake on, first acknowledge after stop entry is long
// - continue-in-stop writes are ignored while in stop mode
// - bit 3 set with handshake: access in the very next bus cycle
// - bit 3 clear with handshake: wait free cycle, force after 512 cycles
// - handshake off: access always steals the next bus cycle
// - bit 2 selects dedicated debug clock or device fast clock
// - clock select is 0 after reset, only reset clears it
// - bit 1 reads 1 when unsecure, 0 when secure
// - mass-clear pending set only by the mass-clear command
// - mass-clear pending clears on completion or soft reset
// - bit 0 reads 1 while mass-clear is pending
// - bits 6, 1, 0 are not writable by any command
// - bits 7, 3, 2 writable only by host write command when not secure
// - register reached only by host serial commands, not memory mapped
package dbg_csh_pkg;
   localparam int BIT_ENABLE   = 7;
   localparam int BIT_ACTIVE   = 6;
   localparam int BIT_CIS      = 5;
   localparam int BIT_STEAL    = 3;
   localparam int BIT_CLKSEL   = 2;
   localparam int BIT_UNSECURE_STATUS    = 1;
   localparam int BIT_CLEARPND = 0;
   localparam logic [7:0] RESET_SPECIAL = 8'hC0;
   localparam logic [7:0] RESET_NORMAL  = 8'h00;
   localparam int STEAL_TIMEOUT  = 512;
   localparam int SERIAL_CLOCK_SELECT_WAIT_CYC = 150;
   localparam int TIMER_W        = 10;
endpackage : dbg_csh_pkg

// ===== debug_ctrl_status_high.sv
// upper control and status byte of the single-wire debug controller
`timescale 1ns/1ps
module debug_ctrl_status_high
   import dbg_csh_pkg::*;
(
   input  wire logic       clock_i,
   input  wire logic       rst_i,
   input  wire logic       clk_en_i,
   input  wire logic       special_mode_i,
   input  wire logic       soft_reset_i,
   input  wire logic       host_status_write_command_i,
   input  wire logic [7:0] host_wdata_i,
   input  wire logic       host_status_read_command_i,
   output logic      [7:0] host_rdata_o,
   input  wire logic       unsecure_i,
   input  wire logic       stop_mode_i,
   input  wire logic       debug_entry_i,
   input  wire logic       debug_exit_i,
   input  wire logic       mass_clear_cmd_i,
   input  wire logic       mass_clear_done_i,
   input  wire logic       ack_enable_i,
   input  wire logic       ack_issue_i,
   output logic            ack_long_o,
   input  wire logic       access_req_i,
   input  wire logic       bus_free_i,
   output logic            access_go_o,
   output logic            debug_enable_o,
   output logic            active_debug_mode_o,
   output logic            keep_serial_clock_o,
   output logic            keep_all_clocks_o,
   output logic            serial_clock_select_o,
   output logic            serial_comm_allow_o,
   output logic            intrusive_allow_o
);

   // register fields of the byte
   logic               enable_r;
   logic               active_r;
   logic               cis_r;
   logic               steal_r;
   logic               clksel_r;
   logic               pend_r;
   // high up to the first enabled edge after reset, which loads the mode values
   logic               strap_r;
   // stop entry seen and not yet answered by an acknowledge
   logic               stop_seen_r;
   logic               stop_d_r;
   // cycles that a debug access has waited for a free bus cycle
   logic [TIMER_W-1:0] wait_r;
   logic [TIMER_W-1:0] wait_nxt;
   logic [7:0]         rdata_r;

   // decoded conditions
   wire                wr_ok;
   wire                cis_wr_ok;
   wire                stop_rise;
   wire                timeout;
   wire                entry_ok;
   wire                strap_enable;
   wire                strap_active;
   wire                go_cond;
   wire [7:0]          csr;

   // only the host write command reaches the byte, and only while unsecure
   assign wr_ok        = host_status_write_command_i & unsecure_i;
   // continue-in-stop is frozen while stop mode lasts
   assign cis_wr_ok    = wr_ok & ~stop_mode_i;
   assign stop_rise    = stop_mode_i & ~stop_d_r;
   // the access is forced once the counter has run the full timeout
   assign timeout      = (wait_r == TIMER_W'(STEAL_TIMEOUT - 1));
   assign entry_ok     = debug_entry_i & enable_r;
   assign strap_enable = special_mode_i ? RESET_SPECIAL[BIT_ENABLE] : RESET_NORMAL[BIT_ENABLE];
   assign strap_active = special_mode_i ? RESET_SPECIAL[BIT_ACTIVE] : RESET_NORMAL[BIT_ACTIVE];
   assign go_cond      = ~ack_enable_i | steal_r | bus_free_i | timeout;
   assign wait_nxt     = (access_req_i & ~access_go_o) ? wait_r + 1'b1 : '0;
   // bit 4 is unimplemented and reads zero
   assign csr          = {enable_r, active_r, cis_r, 1'b0, steal_r, clksel_r,
                          unsecure_i, pend_r};

   // marks the first enabled cycle after reset
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         strap_r <= 1'b1;
      end else if (clk_en_i) begin
         strap_r <= 1'b0;
      end
   end

   // debug enable: mode value after reset, then host writes
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         enable_r <= 1'b0;
      end else if (clk_en_i) begin
         if (strap_r) begin
            enable_r <= strap_enable;
         end else if (wr_ok) begin
            enable_r <= host_wdata_i[BIT_ENABLE];
         end
      end
   end

   // active debug status only moves by hardware events, never by a write
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         active_r <= 1'b0;
      end else if (clk_en_i) begin
         if (strap_r) begin
            active_r <= strap_active;
         end else if (entry_ok) begin
            active_r <= 1'b1;
         end else if (debug_exit_i) begin
            active_r <= 1'b0;
         end
      end
   end

   // continue-in-stop choice
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         cis_r <= 1'b0;
      end else if (clk_en_i) begin
         if (!strap_r && cis_wr_ok) begin
            cis_r <= host_wdata_i[BIT_CIS];
         end
      end
   end

   // immediate access choice
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         steal_r <= 1'b0;
      end else if (clk_en_i) begin
         if (!strap_r && wr_ok) begin
            steal_r <= host_wdata_i[BIT_STEAL];
         end
      end
   end

   // clock select: a written one sticks, only reset clears it
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         clksel_r <= 1'b0;
      end else if (clk_en_i) begin
         if (!strap_r && wr_ok && host_wdata_i[BIT_CLKSEL]) begin
            clksel_r <= 1'b1;
         end
      end
   end

   // mass-clear pending: the command sets it and wins over completion
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         pend_r <= 1'b0;
      end else if (clk_en_i) begin
         if (mass_clear_cmd_i) begin
            pend_r <= 1'b1;
         end else if (mass_clear_done_i || soft_reset_i) begin
            pend_r <= 1'b0;
         end
      end
   end

   // stop entry with debug enabled marks the next acknowledge as long
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         stop_d_r    <= 1'b0;
         stop_seen_r <= 1'b0;
      end else if (clk_en_i) begin
         stop_d_r <= stop_mode_i;
         if (stop_rise && enable_r) begin
            stop_seen_r <= 1'b1;
         end else if (ack_issue_i) begin
            stop_seen_r <= 1'b0;
         end
      end
   end

   // counts while an access waits, restarts once it is granted
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         wait_r <= '0;
      end else if (clk_en_i) begin
         wait_r <= wait_nxt;
      end
   end

   // byte captured by the host read command
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_r <= 8'h00;
      end else if (clk_en_i) begin
         if (host_status_read_command_i) begin
            rdata_r <= csr;
         end
      end
   end

   // outputs
   assign host_rdata_o          = rdata_r;
   assign ack_long_o            = ack_enable_i & stop_seen_r;
   assign access_go_o           = access_req_i & go_cond;
   assign debug_enable_o        = enable_r;
   assign active_debug_mode_o   = active_r & enable_r;
   assign intrusive_allow_o     = enable_r;
   assign keep_serial_clock_o   = enable_r & stop_mode_i;
   assign keep_all_clocks_o     = enable_r & stop_mode_i & cis_r;
   assign serial_comm_allow_o   = enable_r | ~stop_mode_i;
   assign serial_clock_select_o = clksel_r;

   // steps of a host write and of a stop entry, used by the checks below
   sequence host_write_s;
      clk_en_i && !strap_r && wr_ok;
   endsequence
   sequence enable_follows_s;
      enable_r == $past(host_wdata_i[BIT_ENABLE]);
   endsequence
   sequence stop_entry_s;
      clk_en_i && stop_rise && enable_r;
   endsequence

   // register field checks
   clksel_sticky_a: assert property (@(posedge clock_i) disable iff (rst_i)
      $past(clksel_r) && clk_en_i |-> clksel_r)
      else $error("clock select cleared");
   clksel_read_a: assert property (@(posedge clock_i) disable iff (rst_i)
      clk_en_i && host_status_read_command_i |=> host_rdata_o[BIT_CLKSEL] == $past(clksel_r))
      else $error("clock select read wrong");
   cis_stop_a: assert property (@(posedge clock_i) disable iff (rst_i)
      stop_mode_i && stop_d_r && !strap_r |=> $stable(cis_r))
      else $error("cis moved in stop");
   unsecure_status_read_a: assert property (@(posedge clock_i) disable iff (rst_i)
      clk_en_i && host_status_read_command_i |=> host_rdata_o[BIT_UNSECURE_STATUS] == $past(unsecure_i))
      else $error("unsecure bit wrong");
   bit4_zero_a: assert property (@(posedge clock_i) disable iff (rst_i)
      host_rdata_o[4] == 1'b0)
      else $error("bit 4 set");
   strap_load_a: assert property (@(posedge clock_i) disable iff (rst_i)
      strap_r && clk_en_i |=> enable_r == $past(special_mode_i))
      else $error("enable reset value wrong");
   strap_active_a: assert property (@(posedge clock_i) disable iff (rst_i)
      strap_r && clk_en_i |=> active_r == $past(special_mode_i))
      else $error("active reset value wrong");
   enable_write_a: assert property (@(posedge clock_i) disable iff (rst_i)
      host_write_s |=> enable_follows_s)
      else $error("enable write lost");
   secure_wr_a: assert property (@(posedge clock_i) disable iff (rst_i)
      clk_en_i && !strap_r && !unsecure_i && !debug_exit_i |=> $stable(enable_r))
      else $error("write while secure");
   state_freeze_a: assert property (@(posedge clock_i) disable iff (rst_i)
      !clk_en_i |=> $stable({enable_r, active_r, cis_r, steal_r, clksel_r, pend_r}))
      else $error("state moved while disabled");

   // active debug status checks
   active_set_a: assert property (@(posedge clock_i) disable iff (rst_i)
      clk_en_i && !strap_r && entry_ok |=> active_r)
      else $error("active status not set");
   active_clr_a: assert property (@(posedge clock_i) disable iff (rst_i)
      clk_en_i && !strap_r && !entry_ok && debug_exit_i |=> !active_r)
      else $error("active status not cleared");
   active_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
      clk_en_i && !strap_r && !debug_entry_i && !debug_exit_i |=> $stable(active_r))
      else $error("active status written");
   active_enable_a: assert property (@(posedge clock_i) disable iff (rst_i)
      active_debug_mode_o |-> debug_enable_o)
      else $error("active mode without enable");

   // mass-clear pending checks
   pend_set_a: assert property (@(posedge clock_i) disable iff (rst_i)
      clk_en_i && mass_clear_cmd_i |=> pend_r)
      else $error("pending not set");
   pend_only_a: assert property (@(posedge clock_i) disable iff (rst_i)
      clk_en_i && !mass_clear_cmd_i |=> !pend_r || $past(pend_r))
      else $error("pending set without command");
   pend_clr_a: assert property (@(posedge clock_i) disable iff (rst_i)
      clk_en_i && !mass_clear_cmd_i && mass_clear_done_i |=> !pend_r)
      else $error("pending not cleared");
   soft_clr_a: assert property (@(posedge clock_i) disable iff (rst_i)
      clk_en_i && !mass_clear_cmd_i && soft_reset_i |=> !pend_r)
      else $error("pending kept over soft reset");

   // stop and access checks
   long_ack_a: assert property (@(posedge clock_i) disable iff (rst_i)
      stop_entry_s ##1 ack_enable_i |-> ack_long_o)
      else $error("first acknowledge not long");
   keep_serial_a: assert property (@(posedge clock_i) disable iff (rst_i)
      enable_r && stop_mode_i |-> keep_serial_clock_o)
      else $error("serial clock stopped");
   stop_off_a: assert property (@(posedge clock_i) disable iff (rst_i)
      !enable_r |-> !keep_all_clocks_o && !keep_serial_clock_o)
      else $error("stop influence");
   noack_steal_a: assert property (@(posedge clock_i) disable iff (rst_i)
      access_req_i && !ack_enable_i |-> access_go_o)
      else $error("no steal");
   steal_next_a: assert property (@(posedge clock_i) disable iff (rst_i)
      access_req_i && ack_enable_i && steal_r |-> access_go_o)
      else $error("immediate access held");
   force_go_a: assert property (@(posedge clock_i) disable iff (rst_i)
      access_req_i && ack_enable_i && timeout |-> access_go_o)
      else $error("access not forced");
   wait_free_a: assert property (@(posedge clock_i) disable iff (rst_i)
      access_req_i && ack_enable_i && !steal_r && !bus_free_i && !timeout |-> !access_go_o)
      else $error("access took a busy cycle");
endmodule : debug_ctrl_status_high

// ===== dbg_host_model.sv
// behavioural debug host issuing serial register commands
`timescale 1ns/1ps
module dbg_host_model (
   input  wire logic       clock_i,
   output logic            wr_o,
   output logic            rd_o,
   output logic      [7:0] wdata_o
);
   initial {wr_o, rd_o, wdata_o} = 10'h000;
   task automatic wr(input logic [7:0] d);
      @(posedge clock_i) #1 {wr_o, wdata_o} = {1'b1, d};
      @(posedge clock_i) #1 {wr_o, wdata_o} = {1'b0, ~d};
      if (d[2]) repeat (150) @(posedge clock_i);
   endtask : wr
   task automatic rd;
      @(posedge clock_i) #1 rd_o = 1'b1;
      @(posedge clock_i) #1 rd_o = 1'b0;
   endtask : rd
endmodule : dbg_host_model

// ===== tb_top.sv
// self-checking bench for the upper debug control and status byte
`timescale 1ns/1ps
module tb_top;
   logic       clock_i = 0, rst_i = 1, unsecure_status = 1, stop = 0, ack_en = 0, ack_iss = 0;
   logic       mc_cmd = 0, mc_done = 0, acc_req = 0, free = 0;
   logic       clk_en = 1, special = 1, soft_rst = 0, d_entry = 0, d_exit = 0;
   logic       wr, rd, go, ack_long, en, csel, keep_all, comm_ok, act, keep_ser, intr;
   logic [7:0] wd, rdata;
   int         num_errors = 0;
   int         n_tests = 0;
   always #10 clock_i = ~clock_i;
   dbg_host_model u_host (.clock_i(clock_i), .wr_o(wr), .rd_o(rd), .wdata_o(wd));
   debug_ctrl_status_high u_dut (.clock_i(clock_i), .rst_i(rst_i), .clk_en_i(clk_en),
      .special_mode_i(special), .soft_reset_i(soft_rst), .host_status_write_command_i(wr),
      .host_wdata_i(wd), .host_status_read_command_i(rd), .host_rdata_o(rdata),
      .unsecure_i(unsecure_status), .stop_mode_i(stop), .debug_entry_i(d_entry), .debug_exit_i(d_exit),
      .mass_clear_cmd_i(mc_cmd), .mass_clear_done_i(mc_done), .ack_enable_i(ack_en),
      .ack_issue_i(ack_iss), .ack_long_o(ack_long), .access_req_i(acc_req),
      .bus_free_i(free), .access_go_o(go), .debug_enable_o(en), .active_debug_mode_o(act),
      .keep_serial_clock_o(keep_ser), .keep_all_clocks_o(keep_all),
      .serial_clock_select_o(csel), .serial_comm_allow_o(comm_ok), .intrusive_allow_o(intr));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic rd_exp(input logic [7:0] exp);
      u_host.rd();
      chk(rdata, exp, "status byte");
   endtask : rd_exp
   task automatic s_write;
      rd_exp(8'hC2);
      u_host.wr(8'hFF);
      rd_exp(8'hEE);
      chk({6'h00, en, csel}, 8'h03, "enable and clock select");
   endtask : s_write
   task automatic s_stop;
      ack_en = 1;
      stop = 1;
      @(posedge clock_i) #1;
      chk({6'h00, ack_long, keep_all}, 8'h03, "stop ack and clocks");
      chk({7'h00, keep_ser}, 8'h01, "serial clock kept in stop");
      ack_iss = 1;
      @(posedge clock_i) #1 ack_iss = 0;
      chk({7'h00, ack_long}, 8'h00, "later acknowledge normal");
      u_host.wr(8'h00);
      rd_exp(8'h66);
      chk({7'h00, comm_ok}, 8'h00, "serial link in stop");
      chk({7'h00, keep_ser}, 8'h00, "no stop influence disabled");
      stop = 0;
   endtask : s_stop
   task automatic s_secure;
      unsecure_status = 0;
      u_host.wr(8'hFF);
      rd_exp(8'h64);
      unsecure_status = 1;
   endtask : s_secure
   task automatic s_clear;
      mc_cmd = 1;
      @(posedge clock_i) #1 mc_cmd = 0;
      u_host.wr(8'h00);
      rd_exp(8'h47);
      mc_done = 1;
      @(posedge clock_i) #1 mc_done = 0;
      rd_exp(8'h46);
      mc_cmd = 1;
      @(posedge clock_i) #1 mc_cmd = 0;
      soft_rst = 1;
      @(posedge clock_i) #1 soft_rst = 0;
      rd_exp(8'h46);
   endtask : s_clear
   task automatic s_debug;
      u_host.wr(8'h80);
      d_exit = 1;
      @(posedge clock_i) #1 d_exit = 0;
      chk({5'h00, act, intr, keep_ser}, 8'h02, "debug exit");
      d_entry = 1;
      @(posedge clock_i) #1 d_entry = 0;
      chk({5'h00, act, intr, keep_ser}, 8'h06, "debug entry");
      u_host.wr(8'h00);
      d_exit = 1;
      @(posedge clock_i) #1 d_exit = 0;
      d_entry = 1;
      @(posedge clock_i) #1 d_entry = 0;
      rd_exp(8'h06);
   endtask : s_debug
   task automatic s_freeze;
      clk_en = 0;
      u_host.wr(8'h80);
      mc_cmd = 1;
      @(posedge clock_i) #1 mc_cmd = 0;
      clk_en = 1;
      rd_exp(8'h06);
   endtask : s_freeze
   task automatic s_access;
      acc_req = 1;
      #1 chk({7'h00, go}, 8'h00, "wait for free cycle");
      free = 1;
      #1 chk({7'h00, go}, 8'h01, "free cycle taken");
      free = 0;
      repeat (510) @(posedge clock_i);
      #1 chk({7'h00, go}, 8'h00, "still waiting");
      @(posedge clock_i) #1 chk({7'h00, go}, 8'h01, "forced after timeout");
      u_host.wr(8'h08);
      chk({7'h00, go}, 8'h01, "steal next cycle");
      {ack_en, free} = 2'b00;
      u_host.wr(8'h00);
      chk({7'h00, go}, 8'h01, "steal without ack");
      acc_req = 0;
   endtask : s_access
   task automatic s_reset;
      special = 0;
      rst_i = 1;
      @(posedge clock_i) #1 rst_i = 0;
      repeat (2) @(posedge clock_i);
      #1 chk({6'h00, en, csel}, 8'h00, "reset clears clock select");
      rd_exp(8'h02);
      special = 1;
   endtask : s_reset
   task automatic end_of_test;
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (3) @(posedge clock_i);
      #1 rst_i = 0;
      repeat (2) @(posedge clock_i);
      s_write();
      s_stop();
      s_secure();
      s_clear();
      s_debug();
      s_freeze();
      s_access();
      s_reset();
      end_of_test();
   end
   initial begin
      #50us num_errors++;
      end_of_test();
   end
endmodule : tb_top
